// file: logic/asp_port_top.sv
// eight-bit shared analog and digital port with axi4-lite register access
//
// Overview of operation
// - all three control bits zero leaves the pin undriven with no pull-up.
// - select zero, latch one, direction zero enables only the pull-up.
// - select one, latch zero, direction zero drives low with slow slew.
// - select one, latch one, direction zero drives high with slow slew.
// - all three bits one leaves the pin undriven and reads it inverted.
// - each pin level always reaches the digital read and analog channel 8 plus n.
// - the level register returns live pin levels, inverted where so configured.
// - in standby the drive, pull-up and slew outputs keep the state they had on entry; the analog channel keeps following the pins.
// - latch, direction and select are 8-bit read-write, reset zero; level is read-only.
`timescale 1ns/10ps
module asp_port_top
   import asp_pkg::*;
(
   input  wire logic                            aclk,
   input  wire logic                            aresetn,
   input  wire logic [asp_pkg::ASP_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]                      s_axi_awprot,
   input  wire logic                            s_axi_awvalid,
   output logic                                 s_axi_awready,
   input  wire logic [asp_pkg::ASP_DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                      s_axi_wstrb,
   input  wire logic                            s_axi_wvalid,
   output logic                                 s_axi_wready,
   output logic [1:0]                           s_axi_bresp,
   output logic                                 s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   input  wire logic [asp_pkg::ASP_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]                      s_axi_arprot,
   input  wire logic                            s_axi_arvalid,
   output logic                                 s_axi_arready,
   output logic [asp_pkg::ASP_DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                           s_axi_rresp,
   output logic                                 s_axi_rvalid,
   input  wire logic                            s_axi_rready,
   input  wire logic [asp_pkg::ASP_PORT_W-1:0]  pin_level_in,
   output logic [asp_pkg::ASP_PORT_W-1:0]       pin_drive_out,
   output logic [asp_pkg::ASP_PORT_W-1:0]       pin_drive_oe_n,
   output logic [asp_pkg::ASP_PORT_W-1:0]       pin_pullup_en,
   output logic [asp_pkg::ASP_PORT_W-1:0]       pin_slow_slew,
   output logic [asp_pkg::ASP_PORT_W-1:0]       analog_channel_input
);

   import asp_pkg::*;

   // ==========================================================
   // control registers
   logic [ASP_PORT_W-1:0]  pin_output_latch_reg;
   logic [ASP_PORT_W-1:0]  pin_direction_control_reg;
   logic [ASP_PORT_W-1:0]  pin_function_select_b_reg;
   logic                   standby_reg;

   // ==========================================================
   // write channel state
   logic                   aw_full_reg;
   logic [ASP_ADDR_W-1:0]  aw_addr_reg;
   logic                   w_full_reg;
   logic [ASP_DATA_W-1:0]  w_data_reg;
   logic                   w_strb0_reg;
   logic                   bvalid_reg;
   logic [1:0]             bresp_reg;
   logic                   awready_reg;
   logic                   wready_reg;

   // ==========================================================
   // read channel state
   logic                   arready_reg;
   logic                   rvalid_reg;
   logic [ASP_DATA_W-1:0]  rdata_reg;
   logic [1:0]             rresp_reg;

   // ==========================================================
   // pin side state
   logic [ASP_PORT_W-1:0]  pin_sync1_reg;
   logic [ASP_PORT_W-1:0]  pin_sync2_reg;
   logic [ASP_PORT_W-1:0]  analog_reg;
   logic [ASP_PORT_W-1:0]  drive_out_reg;
   logic [ASP_PORT_W-1:0]  drive_oe_n_reg;
   logic [ASP_PORT_W-1:0]  pullup_reg;
   logic [ASP_PORT_W-1:0]  slow_reg;

   // ==========================================================
   // per-pin decode
   logic [ASP_PORT_W-1:0]  dec_drive_en;
   logic [ASP_PORT_W-1:0]  dec_level;
   logic [ASP_PORT_W-1:0]  dec_pullup;
   logic [ASP_PORT_W-1:0]  dec_slow;
   logic [ASP_PORT_W-1:0]  dec_invert;

   genvar gi;
   generate
      for (gi = 0; gi < ASP_PORT_W; gi++) begin : g_pin
         asp_pin_decode u_dec (
            .fsb         (pin_function_select_b_reg[gi]),
            .lat         (pin_output_latch_reg[gi]),
            .ddr         (pin_direction_control_reg[gi]),
            .drive_en    (dec_drive_en[gi]),
            .drive_level (dec_level[gi]),
            .pullup_en   (dec_pullup[gi]),
            .slow_slew   (dec_slow[gi]),
            .read_invert (dec_invert[gi])
         );
      end
   endgenerate

   // ==========================================================
   // live pin read value
   wire [ASP_PORT_W-1:0] pin_read_value = pin_sync2_reg ^ dec_invert;

   // ==========================================================
   // write decode
   wire aw_take    = s_axi_awvalid && s_axi_awready;
   wire w_take     = s_axi_wvalid && s_axi_wready;
   wire wr_fire    = aw_full_reg && w_full_reg && !bvalid_reg;
   wire wr_latch   = (aw_addr_reg == ASP_ADDR_LATCH);
   wire wr_level   = (aw_addr_reg == ASP_ADDR_LEVEL);
   wire wr_dir     = (aw_addr_reg == ASP_ADDR_DIR);
   wire wr_fsb     = (aw_addr_reg == ASP_ADDR_FSB);
   wire wr_standby = (aw_addr_reg == ASP_ADDR_STANDBY);
   wire wr_mapped  = wr_latch || wr_level || wr_dir || wr_fsb || wr_standby;
   wire wr_en      = wr_fire && w_strb0_reg;
   wire [ASP_PORT_W-1:0] wr_byte = w_data_reg[ASP_PORT_W-1:0];
   wire [1:0] wr_resp = wr_mapped ? ASP_RESP_OKAY : ASP_RESP_SLVERR;

   // ==========================================================
   // next holding state of the write path
   wire aw_full_next = aw_take || (aw_full_reg && !wr_fire);
   wire w_full_next  = w_take || (w_full_reg && !wr_fire);
   wire bvalid_next  = wr_fire || (bvalid_reg && !s_axi_bready);

   // ==========================================================
   // read decode
   wire ar_take    = s_axi_arvalid && arready_reg;
   wire rd_latch   = (s_axi_araddr == ASP_ADDR_LATCH);
   wire rd_level   = (s_axi_araddr == ASP_ADDR_LEVEL);
   wire rd_dir     = (s_axi_araddr == ASP_ADDR_DIR);
   wire rd_fsb     = (s_axi_araddr == ASP_ADDR_FSB);
   wire rd_standby = (s_axi_araddr == ASP_ADDR_STANDBY);
   wire rd_mapped  = rd_latch || rd_level || rd_dir || rd_fsb || rd_standby;
   wire [ASP_PORT_W-1:0] rd_byte =
      rd_latch   ? pin_output_latch_reg      :
      rd_level   ? pin_read_value            :
      rd_dir     ? pin_direction_control_reg :
      rd_fsb     ? pin_function_select_b_reg :
      rd_standby ? {{(ASP_PORT_W-1){1'b0}}, standby_reg} :
      ASP_RST_PORT;
   wire [ASP_DATA_W-1:0] rd_word = {{(ASP_DATA_W-ASP_PORT_W){1'b0}}, rd_byte};
   wire [1:0] rd_resp = rd_mapped ? ASP_RESP_OKAY : ASP_RESP_SLVERR;

   // ==========================================================
   // bus outputs
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // ==========================================================
   // pin outputs
   assign pin_drive_out        = drive_out_reg;
   assign pin_drive_oe_n       = drive_oe_n_reg;
   assign pin_pullup_en        = pullup_reg;
   assign pin_slow_slew        = slow_reg;
   assign analog_channel_input = analog_reg;

   // ==========================================================
   // write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (aw_take) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg  <= 1'b0;
         w_data_reg  <= ASP_ZERO_WORD;
         w_strb0_reg <= 1'b0;
      end else if (w_take) begin
         w_full_reg  <= 1'b1;
         w_data_reg  <= s_axi_wdata;
         w_strb0_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         w_full_reg <= 1'b0;
      end
   end

   // ==========================================================
   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= ASP_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_resp;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ==========================================================
   // write readys from flip-flops, loaded from the next holding state so they stay in step with it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
      end else begin
         awready_reg <= !aw_full_next && !bvalid_next;
         wready_reg  <= !w_full_next && !bvalid_next;
      end
   end

   // ==========================================================
   // control register writes; level register ignores writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_output_latch_reg      <= ASP_RST_PORT;
         pin_direction_control_reg <= ASP_RST_PORT;
         pin_function_select_b_reg <= ASP_RST_PORT;
         standby_reg               <= ASP_RST_STANDBY;
      end else if (wr_en) begin
         if (wr_latch) begin
            pin_output_latch_reg <= wr_byte;
         end
         if (wr_dir) begin
            pin_direction_control_reg <= wr_byte;
         end
         if (wr_fsb) begin
            pin_function_select_b_reg <= wr_byte;
         end
         if (wr_standby) begin
            standby_reg <= wr_byte[ASP_STANDBY_BIT];
         end
      end
   end

   // ==========================================================
   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= ASP_ZERO_WORD;
         rresp_reg   <= ASP_RESP_OKAY;
      end else if (ar_take) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_word;
         rresp_reg   <= rd_resp;
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
      end
   end

   // ==========================================================
   // pin input synchroniser and analog channel feed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_sync1_reg <= ASP_RST_PORT;
         pin_sync2_reg <= ASP_RST_PORT;
         analog_reg    <= ASP_RST_PORT;
      end else begin
         pin_sync1_reg <= pin_level_in;
         pin_sync2_reg <= pin_sync1_reg;
         analog_reg    <= pin_sync2_reg;
      end
   end

   // ==========================================================
   // pin drive state, frozen while in standby
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_out_reg  <= ASP_RST_PORT;
         drive_oe_n_reg <= ~ASP_RST_PORT;
         pullup_reg     <= ASP_RST_PORT;
         slow_reg       <= ASP_RST_PORT;
      end else if (!standby_reg) begin
         drive_out_reg  <= dec_level;
         drive_oe_n_reg <= ~dec_drive_en;
         pullup_reg     <= dec_pullup;
         slow_reg       <= dec_slow;
      end
   end

endmodule

// file: logic/asp_pkg.sv
// constants shared by the port top level, its checker and its testbench
package asp_pkg;

   // ==========================================================
   // widths
   localparam int  ASP_ADDR_W   = 18;
   localparam int  ASP_DATA_W   = 32;
   localparam int  ASP_PORT_W   = 8;
   localparam int  ASP_IDX_W    = 16;

   // ==========================================================
   // register indices; byte address is four times the index
   localparam logic [ASP_IDX_W-1:0] ASP_IDX_LATCH   = 16'h7f5c;
   localparam logic [ASP_IDX_W-1:0] ASP_IDX_LEVEL   = 16'h7f5d;
   localparam logic [ASP_IDX_W-1:0] ASP_IDX_DIR     = 16'h7f5e;
   localparam logic [ASP_IDX_W-1:0] ASP_IDX_FSB     = 16'h7ff7;
   localparam logic [ASP_IDX_W-1:0] ASP_IDX_STANDBY = 16'h7ff8;

   localparam logic [ASP_ADDR_W-1:0] ASP_ADDR_LATCH   = {ASP_IDX_LATCH, 2'b00};
   localparam logic [ASP_ADDR_W-1:0] ASP_ADDR_LEVEL   = {ASP_IDX_LEVEL, 2'b00};
   localparam logic [ASP_ADDR_W-1:0] ASP_ADDR_DIR     = {ASP_IDX_DIR, 2'b00};
   localparam logic [ASP_ADDR_W-1:0] ASP_ADDR_FSB     = {ASP_IDX_FSB, 2'b00};
   localparam logic [ASP_ADDR_W-1:0] ASP_ADDR_STANDBY = {ASP_IDX_STANDBY, 2'b00};

   // ==========================================================
   // reset values and fields
   localparam logic [ASP_PORT_W-1:0] ASP_RST_PORT    = 8'h00;
   localparam logic                  ASP_RST_STANDBY = 1'b0;
   localparam int                    ASP_STANDBY_BIT = 0;
   localparam logic [ASP_DATA_W-1:0] ASP_ZERO_WORD   = 32'h0000_0000;

   // ==========================================================
   // bus responses
   localparam logic [1:0] ASP_RESP_OKAY   = 2'b00;
   localparam logic [1:0] ASP_RESP_SLVERR = 2'b10;

endpackage

// file: logic/asp_pin_decode.sv
// per-pin drive state decode from function-select, latch and direction bits
`timescale 1ns/10ps
module asp_pin_decode (
   input  wire logic fsb,
   input  wire logic lat,
   input  wire logic ddr,
   output logic      drive_en,
   output logic      drive_level,
   output logic      pullup_en,
   output logic      slow_slew,
   output logic      read_invert
);

   // ==========================================================
   // eight-state decode
   always_comb begin
      drive_en    = 1'b0;
      drive_level = 1'b0;
      pullup_en   = 1'b0;
      slow_slew   = 1'b0;
      read_invert = 1'b0;
      case ({fsb, lat, ddr})
         3'b000: begin
            drive_en = 1'b0;
         end
         3'b010: begin
            pullup_en = 1'b1;
         end
         3'b001, 3'b011: begin
            drive_en    = 1'b1;
            drive_level = lat;
         end
         3'b100: begin
            drive_en  = 1'b1;
            slow_slew = 1'b1;
         end
         3'b110: begin
            drive_en    = 1'b1;
            drive_level = 1'b1;
            slow_slew   = 1'b1;
         end
         3'b101: begin
            drive_en = 1'b1;
         end
         3'b111: begin
            read_invert = 1'b1;
         end
         default: begin
            drive_en = 1'b0;
         end
      endcase
   end

endmodule

// file: tb/asp_port_properties.sv
// checker for the bus handshakes and pin drive outputs of the port
`timescale 1ns/10ps
module asp_port_properties (
   input wire logic                            aclk,
   input wire logic                            aresetn,
   input wire logic                            s_axi_awvalid,
   input wire logic                            s_axi_awready,
   input wire logic                            s_axi_wvalid,
   input wire logic                            s_axi_wready,
   input wire logic [1:0]                      s_axi_bresp,
   input wire logic                            s_axi_bvalid,
   input wire logic                            s_axi_bready,
   input wire logic                            s_axi_arvalid,
   input wire logic                            s_axi_arready,
   input wire logic [asp_pkg::ASP_DATA_W-1:0]  s_axi_rdata,
   input wire logic                            s_axi_rvalid,
   input wire logic                            s_axi_rready,
   input wire logic [asp_pkg::ASP_PORT_W-1:0]  pin_level_in,
   input wire logic [asp_pkg::ASP_PORT_W-1:0]  pin_drive_oe_n,
   input wire logic [asp_pkg::ASP_PORT_W-1:0]  pin_pullup_en,
   input wire logic [asp_pkg::ASP_PORT_W-1:0]  pin_slow_slew,
   input wire logic [asp_pkg::ASP_PORT_W-1:0]  analog_channel_input
);
   import asp_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // sequences
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_resp;
      ##[1:2] s_axi_bvalid;
   endsequence
   // ==========================================================
   // assertions
   a_pull_undriven: assert property ((pin_pullup_en & ~pin_drive_oe_n) == 8'h00)
      else $error("pull-up on a driven pin");
   a_slow_driven: assert property ((pin_slow_slew & pin_drive_oe_n) == 8'h00)
      else $error("slow slew on an undriven pin");
   a_pins_reset: assert property ($rose(aresetn) |-> pin_drive_oe_n == 8'hFF)
      else $error("pins driven after reset");
   a_analog_delay: assert property (aresetn[*4] |->
      analog_channel_input == $past(pin_level_in, 3))
      else $error("analog channel does not follow pin");
   a_write_answer: assert property (s_wr_both |-> s_wr_resp)
      else $error("write not answered");
   a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
endmodule
bind asp_port_top asp_port_properties i_asp_port_properties (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_level_in(pin_level_in),
   .pin_drive_oe_n(pin_drive_oe_n), .pin_pullup_en(pin_pullup_en),
   .pin_slow_slew(pin_slow_slew), .analog_channel_input(analog_channel_input));

// file: tb/asp_pin_board.sv
// board model: pads resolve device drive, external sources and pull-ups
`timescale 1ns/10ps
module asp_pin_board (
   input wire logic        aclk,
   input wire logic [7:0]  drive_out,
   input wire logic [7:0]  drive_oe_n,
   input wire logic [7:0]  pullup_en,
   input wire logic [7:0]  ext_level,
   input wire logic [7:0]  ext_en,
   output logic [7:0]      pin_level
);
   // a floating pad without pull-up keeps the inverse of its last driven level
   logic [7:0] float_reg = 8'h00;
   wire  [7:0] floating = drive_oe_n & ~ext_en & ~pullup_en;
   always @(posedge aclk) float_reg <= (floating & float_reg) | (~floating & ~pin_level);
   assign pin_level = (~drive_oe_n & drive_out) | (drive_oe_n & ext_en & ext_level)
                    | (drive_oe_n & ~ext_en & (pullup_en | float_reg));
endmodule

// file: tb/asp_port_tb_top.sv
// testbench: corner and random port settings over axi4-lite
`timescale 1ns/10ps
module asp_port_tb_top;
   import asp_pkg::*;
   logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [ASP_ADDR_W-1:0] awaddr, araddr;
   logic [31:0]           wdata, rdata, seed, got, g2;
   logic [1:0]            bresp, rresp, rsp;
   logic [7:0]            pin, oe_n, dout, pull, slow, ana, ext_lvl, ext_en, last_lv, last_iv;
   logic [3:0]            wstrb;
   int                    bad_count, check_count;

   asp_port_top i_asp_port_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_level_in(pin),
      .pin_drive_out(dout), .pin_drive_oe_n(oe_n), .pin_pullup_en(pull),
      .pin_slow_slew(slow), .analog_channel_input(ana));
   asp_pin_board i_asp_pin_board (.aclk(aclk), .drive_out(dout), .drive_oe_n(oe_n),
      .pullup_en(pull), .ext_level(ext_lvl), .ext_en(ext_en), .pin_level(pin));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // ==========================================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected drive enable, pull-up and inverted read masks
   function automatic logic [23:0] exp_state(input logic [7:0] f, l, d);
      return {(d & ~(f & l)) | (f & ~d), ~f & l & ~d, f & l & d};
   endfunction
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e, input string what);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask
   task automatic tmo();
      bad_count++;
      $display("BAD %0t bus timeout", $time);
      end_sim;
   endtask
   task automatic wr(input logic [ASP_ADDR_W-1:0] a, input logic [31:0] dt, input logic [1:0] er);
      bit pa, pw, pb, ha, hw, hb;
      logic [1:0] r;
      int n;
      @(posedge aclk);
      awaddr <= a; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1;
      pa = 1; pw = 1; pb = 1; r = 2'b01;
      for (n = 0; n < 50 && pb; n++) begin
         #1;
         ha = pa && awready; hw = pw && wready; hb = bvalid && bready;
         if (hb) r = bresp;
         @(posedge aclk);
         if (ha) begin awvalid <= 1'b0; pa = 0; end
         if (hw) begin wvalid <= 1'b0; pw = 0; end
         if (hb) begin bready <= 1'b0; pb = 0; end
         else if (n == 3) bready <= 1'b1;
      end
      if (pb) tmo();
      chk(r, er, "write resp");
   endtask
   task automatic rd(input logic [ASP_ADDR_W-1:0] a, output logic [31:0] dt, output logic [1:0] r);
      bit pa, pd, ha, hd;
      int n;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1;
      pa = 1; pd = 1;
      for (n = 0; n < 50 && pd; n++) begin
         #1;
         ha = pa && arready; hd = rvalid && rready; dt = rdata; r = rresp;
         @(posedge aclk);
         if (ha) begin arvalid <= 1'b0; pa = 0; end
         if (hd) begin rready <= 1'b0; pd = 0; end
         else if (n == 2) rready <= 1'b1;
      end
      if (pd) tmo();
   endtask
   // one setting of all pins, then pads, analog and level read compared
   task automatic cfg(input logic [7:0] f, l, d, en, x);
      logic [7:0] dv, pu, iv;
      {dv, pu, iv} = exp_state(f, l, d);
      en = en | ~pu;
      last_lv = (dv & l) | (~dv & en & x) | (~dv & ~en);
      last_iv = iv;
      ext_lvl <= x;
      ext_en <= en;
      wr(ASP_ADDR_LATCH, {24'h00_0000, l}, ASP_RESP_OKAY);
      wr(ASP_ADDR_DIR, {24'h00_0000, d}, ASP_RESP_OKAY);
      wr(ASP_ADDR_FSB, {24'h00_0000, f}, ASP_RESP_OKAY);
      repeat (5) @(posedge aclk);
      #1;
      chk(oe_n, {24'h00_0000, ~dv}, "drive enable");
      chk(dout & dv, l & dv, "drive level");
      chk(pull, pu, "pull-up");
      chk(slow, f & ~d, "slew");
      chk(ana, last_lv, "analog");
      rd(ASP_ADDR_LEVEL, got, rsp);
      chk(got, {24'h00_0000, last_lv ^ iv}, "level read");
      rd(ASP_ADDR_DIR, got, rsp);
      chk(got, {24'h00_0000, d}, "dir read");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      seed = 32'h830c_7093; bad_count = 0; check_count = 0;
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
      ext_lvl = 8'h00; ext_en = 8'hFF;
      wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      chk({oe_n, pull, slow}, 24'hFF_0000, "reset pins");
      rd(ASP_ADDR_LATCH, got, rsp);
      chk(got, 32'h0000_0000, "latch reset");
      rd(ASP_ADDR_DIR, got, rsp);
      chk(got, 32'h0000_0000, "dir reset");
      rd(ASP_ADDR_FSB, got, rsp);
      chk(got, 32'h0000_0000, "fsb reset");
      cfg(8'hF0, 8'hCC, 8'hAA, 8'hFF, 8'h5A);
      cfg(8'hF0, 8'hCC, 8'hAA, 8'h00, 8'hA5);
      repeat (14) begin
         got = xs();
         g2 = xs();
         cfg(got[7:0], got[15:8], got[23:16], got[31:24], g2[7:0]);
      end
      wr(ASP_ADDR_LEVEL, 32'h0000_00FF, ASP_RESP_OKAY);
      rd(ASP_ADDR_LEVEL, got, rsp);
      chk(got, {24'h00_0000, last_lv ^ last_iv}, "level ro");
      wr(18'h0_0100, 32'h0000_0001, ASP_RESP_SLVERR);
      rd(18'h0_0100, got, rsp);
      chk(got, 32'h0000_0000, "unmapped data");
      chk({30'h0000_0000, rsp}, {30'h0000_0000, ASP_RESP_SLVERR}, "unmapped resp");
      cfg(8'h00, 8'h0F, 8'hFF, 8'hFF, 8'h00);
      wr(ASP_ADDR_STANDBY, 32'h0000_0001, ASP_RESP_OKAY);
      wr(ASP_ADDR_LATCH, 32'h0000_00F0, ASP_RESP_OKAY);
      repeat (5) @(posedge aclk);
      #1;
      chk({oe_n, dout}, 16'h000F, "standby hold");
      wr(ASP_ADDR_STANDBY, 32'h0000_0000, ASP_RESP_OKAY);
      repeat (5) @(posedge aclk);
      #1;
      chk({oe_n, dout}, 16'h00F0, "standby exit");
      @(posedge aclk);
      wstrb <= 4'h0;
      wr(ASP_ADDR_LATCH, 32'h0000_000F, ASP_RESP_OKAY);
      wstrb <= 4'hF;
      rd(ASP_ADDR_LATCH, got, rsp);
      chk(got, 32'h0000_00F0, "strobe off");
      end_sim;
   end
endmodule
